/* rtl/port_gpio_pkg.sv */
// Purpose: Constants shared by the port two and port three pin logic.
// Assumes: Registers are reached over the processor core's special
//   function register port with an 8-bit address and 8-bit data.
// Notes: Offsets are the special function register addresses.
package port_gpio_pkg;

  // Width of one port and of the register data path.
  localparam int PORT_WIDTH = 8;
  // Width of the special function register address.
  localparam int ADDR_WIDTH = 8;

  // Register addresses.
  localparam logic [7:0] ADDR_TWO_LATCH = 8'hA0;
  localparam logic [7:0] ADDR_TWO_DRIVE = 8'hA6;
  localparam logic [7:0] ADDR_THREE_DRIVE = 8'hA7;
  localparam logic [7:0] ADDR_THREE_LATCH = 8'hB0;
  localparam logic [7:0] ADDR_TWO_MODE = 8'hF3;
  localparam logic [7:0] ADDR_THREE_MODE = 8'hF4;

  // Reset values.
  localparam logic [7:0] RESET_LATCH = 8'hFF;
  localparam logic [7:0] RESET_DRIVE = 8'h00;
  localparam logic [7:0] RESET_MODE = 8'hFF;
  // Value returned for unmapped addresses and analog pins.
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Bit address split: upper five bits pick the byte, lower three the bit.
  localparam int BIT_SEL_WIDTH = 3;

endpackage : port_gpio_pkg

/* rtl/pin_cell.sv */
// Purpose: One port pin: output stage and two-flop input synchroniser.
// Assumes: Pin level arrives asynchronously from the pad.
// Notes: The first synchroniser flop feeds only the second.
module pin_cell
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic latchBit,
  input wire logic pushPull,
  input wire logic digitalEn,
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  output logic pinLevel
);

  // Synchroniser stages.
  logic syncFirst_reg;
  logic syncSecond_reg;

  // Output stage: low drives 0, high drives 1 only when push-pull.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      padOut <= 1'b1;
      padOe <= 1'b0;
    end
    else if (clkEn)
    begin
      padOut <= latchBit;
      padOe <= ~latchBit | pushPull;
    end
  end

  // Input path: two flops, then masked by the digital input enable into a third flop.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      syncFirst_reg <= 1'b0;
      syncSecond_reg <= 1'b0;
      pinLevel <= 1'b0;
    end
    else if (clkEn)
    begin
      syncFirst_reg <= padIn;
      syncSecond_reg <= syncFirst_reg;
      pinLevel <= syncSecond_reg & digitalEn;
    end
  end

endmodule : pin_cell

/* rtl/port_two_three_gpio.sv */
// Purpose: Port two and port three general-purpose pin logic with its
//   six special function registers.
// Assumes: The core gives byte strobes, bit strobes and a flag for
//   read-modify-write reads on the same clock.
// Notes: Port two pin outputs take the crossbar selection from outside.
module port_two_three_gpio
  import port_gpio_pkg::*;
#(
  parameter int WIDTH = port_gpio_pkg::PORT_WIDTH
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [port_gpio_pkg::ADDR_WIDTH-1:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic sfrBitWrite,
  input wire logic sfrBitValue,
  input wire logic sfrRmwRead,
  input wire logic [WIDTH-1:0] sfrWdata,
  output logic [WIDTH-1:0] sfrRdata,
  input wire logic [WIDTH-1:0] crossbarSel,
  input wire logic [WIDTH-1:0] crossbarOut,
  input wire logic [WIDTH-1:0] portTwoIn,
  output logic [WIDTH-1:0] portTwoOut,
  output logic [WIDTH-1:0] portTwoOe,
  input wire logic [WIDTH-1:0] portThreeIn,
  output logic [WIDTH-1:0] portThreeOut,
  output logic [WIDTH-1:0] portThreeOe,
  output logic [WIDTH-1:0] portTwoAnalog,
  output logic [WIDTH-1:0] portThreeAnalog
);

  // The byte and bit decode assumes exactly eight pins per port, so any
  // other width is refused while the design is elaborated.
  if (WIDTH != PORT_WIDTH)
  begin : g_width_check
    $error("port width must equal eight");
  end

  // Stored registers.
  logic [WIDTH-1:0] portTwoLatch_reg;
  logic [WIDTH-1:0] portThreeLatch_reg;
  logic [WIDTH-1:0] portTwoDrive_reg;
  logic [WIDTH-1:0] portThreeDrive_reg;
  logic [WIDTH-1:0] portTwoMode_reg;
  logic [WIDTH-1:0] portThreeMode_reg;
  // Synchronised, masked pin levels.
  logic [WIDTH-1:0] portTwoLevel;
  logic [WIDTH-1:0] portThreeLevel;
  // Per-pin latch value after the crossbar on port two.
  logic [WIDTH-1:0] portTwoSource;
  // Next value of the read data register.
  logic [WIDTH-1:0] sfrRdata_next;

  // Byte address of a bit write: bit address with the bit index cleared.
  function automatic logic [ADDR_WIDTH-1:0] bitByte
    (input logic [ADDR_WIDTH-1:0] addr);
    bitByte = {addr[ADDR_WIDTH-1:BIT_SEL_WIDTH], {BIT_SEL_WIDTH{1'b0}}};
  endfunction : bitByte

  // Applies a byte or single-bit write to one latch.
  function automatic logic [WIDTH-1:0] latchWrite
    (input logic [WIDTH-1:0] cur, input logic [ADDR_WIDTH-1:0] base);
    logic [WIDTH-1:0] res;
    res = cur;
    if (sfrWrite && sfrAddr == base)
      res = sfrWdata;
    else if (sfrBitWrite && bitByte(sfrAddr) == base)
      res[sfrAddr[BIT_SEL_WIDTH-1:0]] = sfrBitValue;
    latchWrite = res;
  endfunction : latchWrite

  // Port latches, byte and bit addressable.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      portTwoLatch_reg <= RESET_LATCH;
      portThreeLatch_reg <= RESET_LATCH;
    end
    else if (clkEn)
    begin
      portTwoLatch_reg <= latchWrite(portTwoLatch_reg, ADDR_TWO_LATCH);
      portThreeLatch_reg <= latchWrite(portThreeLatch_reg,
                                       ADDR_THREE_LATCH);
    end
  end

  // Drive select and input mode registers, byte writes only.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      portTwoDrive_reg <= RESET_DRIVE;
      portThreeDrive_reg <= RESET_DRIVE;
      portTwoMode_reg <= RESET_MODE;
      portThreeMode_reg <= RESET_MODE;
    end
    else if (clkEn && sfrWrite)
    begin
      if (sfrAddr == ADDR_TWO_DRIVE)
        portTwoDrive_reg <= sfrWdata;
      if (sfrAddr == ADDR_THREE_DRIVE)
        portThreeDrive_reg <= sfrWdata;
      if (sfrAddr == ADDR_TWO_MODE)
        portTwoMode_reg <= sfrWdata;
      if (sfrAddr == ADDR_THREE_MODE)
        portThreeMode_reg <= sfrWdata;
    end
  end

  // Read mux: pins for plain reads, latch for read-modify-write.
  always_comb
  begin
    sfrRdata_next = READ_ZERO;
    case (sfrAddr)
      ADDR_TWO_LATCH:
        sfrRdata_next = sfrRmwRead ? portTwoLatch_reg
                                   : portTwoLevel;
      ADDR_THREE_LATCH:
        sfrRdata_next = sfrRmwRead ? portThreeLatch_reg
                                   : portThreeLevel;
      ADDR_TWO_DRIVE: sfrRdata_next = portTwoDrive_reg;
      ADDR_THREE_DRIVE: sfrRdata_next = portThreeDrive_reg;
      ADDR_TWO_MODE: sfrRdata_next = portTwoMode_reg;
      ADDR_THREE_MODE: sfrRdata_next = portThreeMode_reg;
      default: sfrRdata_next = READ_ZERO;
    endcase
  end

  // Read data register, answered one cycle after the read strobe.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sfrRdata <= READ_ZERO;
    else if (clkEn && sfrRead)
      sfrRdata <= sfrRdata_next;
  end

  // Analog flags: registered inverse of the mode bits.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      portTwoAnalog <= ~RESET_MODE;
      portThreeAnalog <= ~RESET_MODE;
    end
    else if (clkEn)
    begin
      portTwoAnalog <= ~portTwoMode_reg;
      portThreeAnalog <= ~portThreeMode_reg;
    end
  end

  // Crossbar: a selected pin carries the latch, others the peripheral.
  assign portTwoSource = (portTwoLatch_reg & crossbarSel) |
                         (crossbarOut & ~crossbarSel);

  // One cell per pin; bit n of each register serves pin n.
  genvar n;
  generate
    for (n = 0; n < WIDTH; n++)
    begin : g_pin
      pin_cell u_two
      (
        .sys_clk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .latchBit(portTwoSource[n]),
        .pushPull(portTwoDrive_reg[n]),
        .digitalEn(portTwoMode_reg[n]),
        .padIn(portTwoIn[n]),
        .padOut(portTwoOut[n]),
        .padOe(portTwoOe[n]),
        .pinLevel(portTwoLevel[n])
      );
      pin_cell u_three
      (
        .sys_clk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .latchBit(portThreeLatch_reg[n]),
        .pushPull(portThreeDrive_reg[n]),
        .digitalEn(portThreeMode_reg[n]),
        .padIn(portThreeIn[n]),
        .padOut(portThreeOut[n]),
        .padOe(portThreeOe[n]),
        .pinLevel(portThreeLevel[n])
      );
    end
  endgenerate

  // Assertions on pin drive and register behaviour.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A latch-driven low bit enables the port three driver next cycle.
  low_drives_a: assert property (
    clkEn && !portThreeLatch_reg[0] ##1 clkEn |->
      portThreeOe[0] && !portThreeOut[0])
    else $error("port three low bit not driven low");

  // Open-drain high floats the pin.
  od_float_a: assert property (
    clkEn && crossbarSel[1] && portTwoLatch_reg[1] &&
      !portTwoDrive_reg[1] ##1 clkEn |-> !portTwoOe[1])
    else $error("open-drain high bit was driven");

  // Push-pull high drives the pin high.
  pp_drive_a: assert property (
    clkEn && portThreeLatch_reg[2] && portThreeDrive_reg[2] ##1 clkEn
      |-> portThreeOe[2] && portThreeOut[2])
    else $error("push-pull high bit not driven");

  // A byte write lands in the latch one cycle later.
  byte_write_a: assert property (
    clkEn && sfrWrite && sfrAddr == ADDR_THREE_LATCH |=>
      portThreeLatch_reg == $past(sfrWdata))
    else $error("port three byte write lost");

  // A bit write leaves the other seven bits alone.
  bit_write_a: assert property (
    clkEn && sfrBitWrite && !sfrWrite &&
      bitByte(sfrAddr) == ADDR_TWO_LATCH |=>
      portTwoLatch_reg[$past(sfrAddr[BIT_SEL_WIDTH-1:0])] ==
        $past(sfrBitValue) &&
      $countones(portTwoLatch_reg ^ $past(portTwoLatch_reg)) <= 1)
    else $error("bit write disturbed other bits");

  // A read-modify-write read returns the latch, not the pins.
  rmw_read_a: assert property (
    clkEn && sfrRead && sfrRmwRead && sfrAddr == ADDR_TWO_LATCH |=>
      sfrRdata == $past(portTwoLatch_reg))
    else $error("read-modify-write returned pins");

  // A plain read returns the synchronised pin level.
  pin_read_a: assert property (
    clkEn && sfrRead && !sfrRmwRead && sfrAddr == ADDR_TWO_LATCH |=>
      sfrRdata == $past(portTwoLevel))
    else $error("plain read did not return pins");

  // An analog pin never reads high.
  analog_zero_a: assert property (
    clkEn && !portThreeMode_reg[3] ##1 clkEn |-> !portThreeLevel[3])
    else $error("analog pin read as high");

  // Main scenarios that the bench should reach.
  byte_write_c: cover property (
    clkEn && sfrWrite && sfrAddr == ADDR_TWO_LATCH);
  bit_write_c: cover property (
    clkEn && sfrBitWrite && bitByte(sfrAddr) == ADDR_THREE_LATCH);
  rmw_read_c: cover property (clkEn && sfrRead && sfrRmwRead);
  analog_pin_c: cover property (clkEn && portTwoAnalog != '0);

endmodule : port_two_three_gpio

/* tb/port_pads.sv */
// Purpose: Pads outside ports two and three, with weak pull-ups.
// Assumes: A released pin floats high unless sunk from outside.
// Notes: extLow models an outside device sinking the pin.
module port_pads
(
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] extLow,
  output logic [7:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  // A driven pin shows its driver, a released one the pull or sink.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pinLevel[i] = padOe[i] ? padOut[i] : ~extLow[i];
    end
  end
endmodule : port_pads

/* tb/port_two_three_gpio_tb.sv */
// Purpose: Self-checking bench for the port two and three pin logic.
// Assumes: Writes land on the strobe edge, reads settle in two cycles.
// Notes: Pins pass a two-flop synchroniser, so reads wait a few cycles.
module port_two_three_gpio_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import port_gpio_pkg::*;
  typedef struct {logic [7:0] lat, drv, mode, ext, oe, rd;} row_s;
  logic sys_clk = 0, rst = 1, sfrWrite = 0, sfrRead = 0, clkEn = 1;
  logic sfrBitWrite = 0, sfrBitValue = 0, sfrRmwRead = 0;
  logic [7:0] sfrAddr = 0, sfrWdata = 0, sfrRdata, xSel = 8'hFF, xOut = 0;
  logic [7:0] in2, out2, oe2, in3, out3, oe3, an2, an3, got;
  logic [7:0] ext[2] = '{8'h00, 8'h00};
  int mismatches = 0, num_checks = 0;
  row_s rows[4];
  // Device under test with both ports wired to the pad model.
  port_two_three_gpio dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
    .sfrBitWrite(sfrBitWrite), .sfrBitValue(sfrBitValue),
    .sfrRmwRead(sfrRmwRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .crossbarSel(xSel), .crossbarOut(xOut), .portTwoIn(in2),
    .portTwoOut(out2), .portTwoOe(oe2), .portThreeIn(in3),
    .portThreeOut(out3), .portThreeOe(oe3), .portTwoAnalog(an2),
    .portThreeAnalog(an3));
  port_pads padsTwo (.padOut(out2), .padOe(oe2), .extLow(ext[0]),
    .pinLevel(in2));
  port_pads padsThree (.padOut(out3), .padOe(oe3), .extLow(ext[1]),
    .pinLevel(in3));
  // Free-running 100 ns clock.
  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] g, input logic [7:0] e,
    input string m);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: %s %h/%h", $time, m, g, e);
    end
  endtask : chk
  // Byte write held for one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #10;
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1;
    @(posedge sys_clk) #10;
    sfrWrite = 0;
  endtask : wr
  // Single-bit write to a bit address.
  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge sys_clk) #10;
    sfrAddr = a;
    sfrBitValue = v;
    sfrBitWrite = 1;
    @(posedge sys_clk) #10;
    sfrBitWrite = 0;
  endtask : bw
  // Read held two edges; rmw asks for the stored latch.
  task automatic rd(input logic [7:0] a, input logic rmw);
    repeat (4) @(posedge sys_clk);
    #10;
    sfrAddr = a;
    sfrRmwRead = rmw;
    sfrRead = 1;
    repeat (2) @(posedge sys_clk);
    #10;
    got = sfrRdata;
    sfrRead = 0;
    sfrRmwRead = 0;
  endtask : rd
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // Cuts a hung run short.
  initial
  begin
    #400000;
    mismatches++;
    results();
  end
  // Main sequence: reset values, table rows, then awkward cases.
  initial
  begin
    logic [7:0] aL, aD, aM;
    rows[0] = '{8'h55, 8'h0F, 8'hFF, 8'h00, 8'hAF, 8'h55};
    rows[1] = '{8'hFF, 8'h00, 8'hFF, 8'h3C, 8'h00, 8'hC3};
    rows[2] = '{8'hF0, 8'hCC, 8'h0F, 8'hFF, 8'hCF, 8'h00};
    rows[3] = '{8'h81, 8'hFF, 8'hA5, 8'h7E, 8'hFF, 8'h81};
    repeat (3) @(posedge sys_clk);
    #10 rst = 0;
    rd(ADDR_TWO_LATCH, 1);
    chk(got, 8'hFF, "two latch reset");
    rd(ADDR_THREE_DRIVE, 0);
    chk(got, 8'h00, "three drive reset");
    rd(ADDR_TWO_MODE, 0);
    chk(got, 8'hFF, "two mode reset");
    chk(oe3, 8'h00, "three released at reset");
    // Port two pins carry the latch while every crossbar select is set.
    for (int p = 0; p < 2; p++)
    begin
      aL = p ? ADDR_THREE_LATCH : ADDR_TWO_LATCH;
      aD = p ? ADDR_THREE_DRIVE : ADDR_TWO_DRIVE;
      aM = p ? ADDR_THREE_MODE : ADDR_TWO_MODE;
      foreach (rows[i])
      begin
        ext[p] = rows[i].ext;
        wr(aL, rows[i].lat);
        wr(aD, rows[i].drv);
        wr(aM, rows[i].mode);
        rd(aL, 0);
        chk(got, rows[i].rd, "pin read");
        chk(p ? oe3 : oe2, rows[i].oe, "enable");
        chk((p ? out3 : out2) & rows[i].oe, rows[i].lat & rows[i].oe,
          "drive level");
        chk(p ? an3 : an2, ~rows[i].mode, "analog");
        rd(aD, 0);
        chk(got, rows[i].drv, "drive readback");
        rd(aM, 0);
        chk(got, rows[i].mode, "mode readback");
      end
    end
    ext = '{8'hFF, 8'h00};
    wr(ADDR_TWO_DRIVE, 8'h00);
    wr(ADDR_TWO_MODE, 8'hFF);
    wr(ADDR_TWO_LATCH, 8'hFF);
    rd(ADDR_TWO_LATCH, 0);
    chk(got, 8'h00, "sunk pins");
    rd(ADDR_TWO_LATCH, 1);
    chk(got, 8'hFF, "rmw latch");
    bw(ADDR_TWO_LATCH + 8'h05, 1'b0);
    rd(ADDR_TWO_LATCH, 1);
    chk(got, 8'hDF, "bit clear");
    bw(ADDR_THREE_LATCH + 8'h07, 1'b0);
    bw(ADDR_THREE_LATCH + 8'h00, 1'b0);
    rd(ADDR_THREE_LATCH, 1);
    chk(got, 8'h00, "three bits");
    // The crossbar hands every port two pin to the peripheral side.
    ext = '{8'h00, 8'h00};
    xSel = 8'h00;
    xOut = 8'hFF;
    wr(ADDR_TWO_DRIVE, 8'hFF);
    wr(ADDR_TWO_LATCH, 8'h00);
    rd(ADDR_TWO_LATCH, 0);
    chk(got, 8'hFF, "crossbar pins");
    rd(ADDR_TWO_LATCH, 1);
    chk(got, 8'h00, "latch kept");
    rd(8'h91, 0);
    chk(got, READ_ZERO, "unmapped read");
    // A write while the clock enable is low must leave the latch alone.
    clkEn = 0;
    wr(ADDR_THREE_LATCH, 8'h5A);
    clkEn = 1;
    rd(ADDR_THREE_LATCH, 1);
    chk(got, 8'h00, "frozen latch");
    // A reset in mid-run brings every register back to its reset value.
    @(posedge sys_clk) #10 rst = 1;
    repeat (3) @(posedge sys_clk);
    #10 rst = 0;
    rd(ADDR_THREE_LATCH, 1);
    chk(got, RESET_LATCH, "latch after reset");
    rd(ADDR_TWO_DRIVE, 0);
    chk(got, RESET_DRIVE, "drive after reset");
    rd(ADDR_THREE_MODE, 0);
    chk(got, RESET_MODE, "mode after reset");
    chk(an3, ~RESET_MODE, "analog after reset");
    chk(oe2, 8'h00, "two released after reset");
    results();
  end
endmodule : port_two_three_gpio_tb
